// ==== src/status_event_reporting.sv ====
// status event registers, masks, summary bits and error queue of the remote interface
`timescale 1ns/100ps
module status_event_reporting (
   // clock and reset
   input  wire logic                          CLK,
   input  wire logic                          RESET_N,
   // executed commands
   input  wire logic                          CMD_VALID,
   input  wire logic [3:0]                    CMD_OP,
   input  wire logic [status_pkg::QD_W-1:0]   CMD_ARG,
   // error events from the instrument
   input  wire logic                          EVT_QUERY_EMPTY,
   input  wire logic                          EVT_QUERY_INTERRUPTED,
   input  wire logic                          EVT_BUFFERS_FULL,
   input  wire logic                          EVT_SELFTEST_FAIL,
   input  wire logic                          EVT_CAL_FAIL,
   input  wire logic                          EVT_EXEC_ERROR,
   input  wire logic                          EVT_SYNTAX_ERROR,
   input  wire logic [status_pkg::CODE_W-1:0] ERR_CODE,
   // measurement events
   input  wire logic                          EVT_OVLD_VOLT,
   input  wire logic                          EVT_OVLD_CURR,
   input  wire logic                          EVT_OVLD_OHMS,
   input  wire logic                          EVT_LIMIT_LO,
   input  wire logic                          EVT_LIMIT_HI,
   input  wire logic                          OUT_BUF_FULL,
   // stored power-on settings
   input  wire logic                          POC_STORED,
   input  wire logic [status_pkg::SE_W-1:0]   STD_MASK_STORED,
   // answers and status
   output logic                               RESP_VALID,
   output logic      [status_pkg::QD_W-1:0]   RESP_DATA,
   output logic      [7:0]                    STATUS_SUMMARY,
   output logic                               POC_SETTING,
   output logic      [status_pkg::SE_W-1:0]   STD_MASK,
   output logic                               READINGS_HALT,
   output logic                               ERROR_PENDING
);
   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic                        init_done;
      logic                        poc;
      logic [status_pkg::SE_W-1:0] std_mask;
      logic [status_pkg::QD_W-1:0] ques_mask;
      logic                        resp_valid;
      logic [status_pkg::QD_W-1:0] resp_data;
      logic                        halt;
      logic                        err_pending;
   } state_t;

   state_t                             s_reg;
   state_t                             s_next;
   status_pkg::cmd_t                   op;
   wire  [status_pkg::SE_W-1:0]        std_set;
   wire  [status_pkg::QD_W-1:0]        ques_set;
   logic [status_pkg::SE_W-1:0]        std_events;
   logic [status_pkg::QD_W-1:0]        ques_events;
   logic                               std_sum;
   logic                               ques_sum;
   logic                               clr_all;
   logic                               std_rd;
   logic                               ques_rd;
   logic                               err_rd;
   logic                               overload;
   logic                               err_push;
   logic [status_pkg::CODE_W-1:0]      q_head;
   logic [status_pkg::ERRQ_CNT_W-1:0]  q_count;

   //---------------------------------------------------------------------------
   // command decode
   //---------------------------------------------------------------------------
   assign op      = status_pkg::cmd_t'(CMD_OP);
   assign clr_all = CMD_VALID && (op == status_pkg::CMD_CLEAR_STATUS);
   assign std_rd  = CMD_VALID && (op == status_pkg::CMD_STD_EVENT_RD);
   assign ques_rd = CMD_VALID && (op == status_pkg::CMD_QUES_EVENT_RD);
   assign err_rd  = CMD_VALID && (op == status_pkg::CMD_ERROR_RD);

   //---------------------------------------------------------------------------
   // event sources
   //---------------------------------------------------------------------------
   assign overload = EVT_OVLD_VOLT || EVT_OVLD_CURR || EVT_OVLD_OHMS;

   // commands arrive in execution order, so all earlier ones are done here
   assign std_set =
      ({7'h00, CMD_VALID && (op == status_pkg::CMD_OP_COMPLETE)} << status_pkg::SE_OPC)
    | ({7'h00, EVT_QUERY_EMPTY || EVT_QUERY_INTERRUPTED || EVT_BUFFERS_FULL}
        << status_pkg::SE_QUERY)
    | ({7'h00, EVT_SELFTEST_FAIL || EVT_CAL_FAIL || overload} << status_pkg::SE_DEVICE)
    | ({7'h00, EVT_EXEC_ERROR} << status_pkg::SE_EXEC)
    | ({7'h00, EVT_SYNTAX_ERROR} << status_pkg::SE_CMD);

   assign ques_set =
      ({15'h0000, EVT_OVLD_VOLT} << status_pkg::QD_VOLT)
    | ({15'h0000, EVT_OVLD_CURR} << status_pkg::QD_CURR)
    | ({15'h0000, EVT_OVLD_OHMS} << status_pkg::QD_OHMS)
    | ({15'h0000, EVT_LIMIT_LO} << status_pkg::QD_LO)
    | ({15'h0000, EVT_LIMIT_HI} << status_pkg::QD_HI);

   // overloads alone never enter the queue
   assign err_push = EVT_QUERY_EMPTY || EVT_QUERY_INTERRUPTED || EVT_BUFFERS_FULL
                   || EVT_SELFTEST_FAIL || EVT_CAL_FAIL || EVT_EXEC_ERROR
                   || EVT_SYNTAX_ERROR;

   //---------------------------------------------------------------------------
   // event registers and error queue
   //---------------------------------------------------------------------------
   event_latch #(
      .W    (status_pkg::SE_W),
      .USED (status_pkg::SE_USED),
      .RST  (status_pkg::SE_RESET)
   ) std_latch (
      .clk      (CLK),
      .rst_n    (RESET_N),
      .set_bits (std_set),
      .clear    (clr_all || std_rd),
      .mask     (s_reg.std_mask),
      .events   (std_events),
      .summary  (std_sum)
   );

   event_latch #(
      .W    (status_pkg::QD_W),
      .USED (status_pkg::QD_USED),
      .RST  (status_pkg::QD_RESET)
   ) ques_latch (
      .clk      (CLK),
      .rst_n    (RESET_N),
      .set_bits (ques_set),
      .clear    (clr_all || ques_rd),
      .mask     (s_reg.ques_mask),
      .events   (ques_events),
      .summary  (ques_sum)
   );

   error_queue err_queue (
      .clk       (CLK),
      .rst_n     (RESET_N),
      .push      (err_push),
      .push_code (ERR_CODE),
      .pop       (err_rd),
      .head      (q_head),
      .count     (q_count)
   );

   //---------------------------------------------------------------------------
   // masks, settings and answers
   //---------------------------------------------------------------------------
   always_comb begin
      s_next             = s_reg;
      s_next.init_done   = 1'b1;
      s_next.resp_valid  = 1'b0;
      s_next.resp_data   = '0;
      s_next.halt        = OUT_BUF_FULL;
      s_next.err_pending = (q_count != '0);
      // power-on: catch stored settings once after reset release
      if (!s_reg.init_done) begin
         s_next.poc       = POC_STORED;
         s_next.std_mask  = POC_STORED ? '0 : STD_MASK_STORED;
         s_next.ques_mask = '0;
      end
      if (CMD_VALID) begin
         unique case (op)
            status_pkg::CMD_STD_MASK_WR: begin
               s_next.std_mask = CMD_ARG[status_pkg::SE_W-1:0];
            end
            status_pkg::CMD_QUES_MASK_WR: begin
               s_next.ques_mask = CMD_ARG;
            end
            status_pkg::CMD_STATUS_PRESET: begin
               s_next.ques_mask = '0;
            end
            status_pkg::CMD_POC_WR: begin
               s_next.poc = CMD_ARG[0];
            end
            status_pkg::CMD_STD_MASK_RD: begin
               s_next.resp_valid = 1'b1;
               s_next.resp_data  = {8'h00, s_reg.std_mask};
            end
            status_pkg::CMD_QUES_MASK_RD: begin
               s_next.resp_valid = 1'b1;
               s_next.resp_data  = s_reg.ques_mask;
            end
            status_pkg::CMD_STD_EVENT_RD: begin
               s_next.resp_valid = 1'b1;
               s_next.resp_data  = {8'h00, std_events};
            end
            status_pkg::CMD_QUES_EVENT_RD: begin
               s_next.resp_valid = 1'b1;
               s_next.resp_data  = ques_events;
            end
            status_pkg::CMD_POC_RD: begin
               s_next.resp_valid = 1'b1;
               s_next.resp_data  = {15'h0000, s_reg.poc};
            end
            status_pkg::CMD_ERROR_RD: begin
               s_next.resp_valid = 1'b1;
               s_next.resp_data  = (q_count == '0) ? status_pkg::NO_ERROR : q_head;
            end
            // clear-status and operation-complete act only on the event latches
            status_pkg::CMD_CLEAR_STATUS,
            status_pkg::CMD_OP_COMPLETE: begin
               s_next.resp_valid = 1'b0;
            end
            default: begin
               s_next.resp_valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   //---------------------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------------------
   assign RESP_VALID     = s_reg.resp_valid;
   assign RESP_DATA      = s_reg.resp_data;
   assign STATUS_SUMMARY = {2'b00, std_sum, 1'b0, ques_sum, 3'b000};
   assign POC_SETTING    = s_reg.poc;
   assign STD_MASK       = s_reg.std_mask;
   assign READINGS_HALT  = s_reg.halt;
   assign ERROR_PENDING  = s_reg.err_pending;

   //---------------------------------------------------------------------------
   // checks
   //---------------------------------------------------------------------------
   default clocking chk_cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   chk_opc_sets_bit: assert property (
      CMD_VALID && op == status_pkg::CMD_OP_COMPLETE |=> std_events[status_pkg::SE_OPC])
      else $error("operation complete bit not set");

   chk_halt_on_full: assert property (
      OUT_BUF_FULL |=> READINGS_HALT ##0 (!$past(OUT_BUF_FULL, 2) || READINGS_HALT))
      else $error("readings not halted on full buffer");

   chk_std_summary_or: assert property (
      STATUS_SUMMARY[status_pkg::STB_STD] == |(std_events & $past(s_reg.std_mask)))
      else $error("standard summary wrong");

   chk_error_push_one: assert property (
      EVT_SYNTAX_ERROR && !err_rd && q_count < 5'(status_pkg::ERRQ_DEPTH) |=> q_count == $past(q_count) + 5'h01)
      else $error("error not queued");

   chk_overload_no_entry: assert property (
      EVT_OVLD_OHMS && !err_push && !err_rd
      |=> std_events[status_pkg::SE_DEVICE] && ques_events[status_pkg::QD_OHMS]
          && q_count == $past(q_count))
      else $error("overload reporting wrong");

   chk_query_error_bit: assert property (
      EVT_QUERY_EMPTY || EVT_BUFFERS_FULL |=> std_events[status_pkg::SE_QUERY])
      else $error("query error bit missing");

   chk_exec_cmd_bits: assert property (
      EVT_EXEC_ERROR && EVT_SYNTAX_ERROR |=> std_events[status_pkg::SE_EXEC] && std_events[status_pkg::SE_CMD])
      else $error("execution or command bit missing");

   chk_power_on_bit: assert property (
      !s_reg.init_done |-> std_events == status_pkg::SE_RESET)
      else $error("power-on bit missing after reset");

   chk_unused_zero: assert property (
      (std_events & ~status_pkg::SE_USED) == '0 && (ques_events & ~status_pkg::QD_USED) == '0)
      else $error("unused bit set");

   chk_std_read_clear: assert property (
      std_rd && std_set == '0
      |=> std_events == '0 && RESP_VALID && RESP_DATA == {8'h00, $past(std_events)})
      else $error("standard event read not destructive");

   chk_limit_bits: assert property (
      EVT_LIMIT_LO && EVT_LIMIT_HI |=> ques_events[status_pkg::QD_LO] && ques_events[status_pkg::QD_HI])
      else $error("limit bits missing");

   chk_ques_read_clear: assert property (
      ques_rd && ques_set == '0 |=> ques_events == '0)
      else $error("questionable read not destructive");

   chk_ques_preset: assert property (
      CMD_VALID && op == status_pkg::CMD_STATUS_PRESET |=> s_reg.ques_mask == '0)
      else $error("preset left questionable mask");

   chk_init_masks: assert property (
      !s_reg.init_done && !CMD_VALID
      |=> s_reg.ques_mask == '0 && STD_MASK == ($past(POC_STORED) ? 8'h00 : $past(STD_MASK_STORED)))
      else $error("power-on masks wrong");

   chk_ques_summary_or: assert property (
      STATUS_SUMMARY[status_pkg::STB_QUES] == |(ques_events & $past(s_reg.ques_mask)))
      else $error("questionable summary wrong");

   chk_clear_summary: assert property (
      clr_all && std_set == '0 && ques_set == '0 |=> STATUS_SUMMARY == 8'h00)
      else $error("clear-status left summary");

   chk_mask_keep: assert property (
      clr_all |=> $stable(s_reg.std_mask) && $stable(s_reg.ques_mask))
      else $error("mask changed by clear-status");

   chk_sticky_bits: assert property (
      !clr_all && !std_rd |=> (std_events & $past(std_events)) == $past(std_events))
      else $error("event bit lost");

   chk_queue_full_keep: assert property (
      q_count == 5'(status_pkg::ERRQ_DEPTH) && !err_rd
      |=> q_count == 5'(status_pkg::ERRQ_DEPTH) && q_head == $past(q_head))
      else $error("full queue changed");

   chk_std_mask_write: assert property (
      CMD_VALID && op == status_pkg::CMD_STD_MASK_WR |=> {8'h00, STD_MASK} == ($past(CMD_ARG) & 16'h00ff))
      else $error("standard mask write lost");

   chk_ques_mask_write: assert property (
      CMD_VALID && op == status_pkg::CMD_QUES_MASK_WR |=> s_reg.ques_mask == $past(CMD_ARG))
      else $error("questionable mask write lost");

   chk_device_error_bit: assert property (
      EVT_SELFTEST_FAIL || EVT_CAL_FAIL |=> std_events[status_pkg::SE_DEVICE])
      else $error("device error bit missing");

   chk_error_read_pop: assert property (
      err_rd && q_count != '0 && !err_push
      |=> RESP_VALID && RESP_DATA == $past(q_head) && q_count == $past(q_count) - 5'h01)
      else $error("error read did not return oldest entry");

   chk_empty_read_zero: assert property (
      err_rd && q_count == '0 |=> RESP_VALID && RESP_DATA == status_pkg::NO_ERROR)
      else $error("empty error read not zero");

   chk_error_pending: assert property (
      ERROR_PENDING == ($past(q_count) != '0))
      else $error("pending flag wrong");

   cov_opc_summary: cover property (
      CMD_VALID && op == status_pkg::CMD_OP_COMPLETE ##1 STATUS_SUMMARY[status_pkg::STB_STD]);
   cov_queue_full: cover property (q_count == 5'(status_pkg::ERRQ_DEPTH) && err_push);
   cov_error_read: cover property (err_rd && q_count != '0 ##1 RESP_VALID);
   cov_set_during_clear: cover property (std_rd && std_set != '0);
endmodule

// ==== src/status_pkg.sv ====
// constants, field layout and command codes of the status event reporting block
//------------------------------------------------------------------------------
// Notes on behaviour
// - operation-complete command sets standard event bit 0 after earlier commands executed.
// - while the output buffer is full, new readings are stopped.
// - standard event bits gated by their mask are ORed into one summary bit.
// - query, device, execution or command errors push an error queue entry, except overloads.
// - reading overload sets device-error bit 3 and questionable bit 0, 1 or 9, no entry.
// - query-error bit 2 on empty read, interrupted query or both buffers full.
// - standard event bit 3 on self-test failure, calibration failure or reading overload.
// - standard event bit 4 when a command fails during execution.
// - standard event bit 5 when a received command has a syntax error.
// - standard event bit 7 is set after power-up until read or cleared.
// - clear-status and the standard event query clear the standard event register.
// - standard mask cleared by writing 0, and at power-on when the stored setting is 1.
// - questionable bit 0 voltage-type, bit 1 current, bit 9 resistance overload.
// - questionable bit 11 below lower limit, bit 12 above upper limit.
// - clear-status and the questionable event query clear the questionable register.
// - questionable mask cleared at every power-on, on preset and by writing 0.
// - error queue holds 20 entries, returned oldest first.
// - questionable bits gated by their mask are ORed into the questionable summary.
// - mask and event queries return the binary-weighted value of the set bits.
// - clear-status zeroes the status byte summary and every event register.
// - questionable summary is status byte bit 3, standard summary is bit 5.
// - reading a mask or clear-status leaves every mask unchanged.
//------------------------------------------------------------------------------
package status_pkg;
   localparam int SE_W        = 8;
   localparam int QD_W        = 16;
   localparam int CODE_W      = 16;
   localparam int ERRQ_DEPTH  = 20;
   localparam int ERRQ_CNT_W  = 5;
   // standard event bit positions
   localparam int SE_OPC      = 0;
   localparam int SE_QUERY    = 2;
   localparam int SE_DEVICE   = 3;
   localparam int SE_EXEC     = 4;
   localparam int SE_CMD      = 5;
   localparam int SE_PON      = 7;
   // questionable data bit positions
   localparam int QD_VOLT     = 0;
   localparam int QD_CURR     = 1;
   localparam int QD_OHMS     = 9;
   localparam int QD_LO       = 11;
   localparam int QD_HI       = 12;
   // status byte summary positions
   localparam int STB_QUES    = 3;
   localparam int STB_STD     = 5;
   localparam logic [SE_W-1:0]   SE_USED     = 8'hbd;
   localparam logic [QD_W-1:0]   QD_USED     = 16'h1a03;
   localparam logic [SE_W-1:0]   SE_RESET    = 8'h80;
   localparam logic [QD_W-1:0]   QD_RESET    = 16'h0000;
   localparam logic [CODE_W-1:0] NO_ERROR    = 16'h0000;
   typedef enum logic [3:0] {
      CMD_CLEAR_STATUS  = 4'h1,
      CMD_OP_COMPLETE   = 4'h2,
      CMD_STD_MASK_WR   = 4'h3,
      CMD_STD_MASK_RD   = 4'h4,
      CMD_STD_EVENT_RD  = 4'h5,
      CMD_QUES_MASK_WR  = 4'h6,
      CMD_QUES_MASK_RD  = 4'h7,
      CMD_QUES_EVENT_RD = 4'h8,
      CMD_STATUS_PRESET = 4'h9,
      CMD_POC_WR        = 4'ha,
      CMD_POC_RD        = 4'hb,
      CMD_ERROR_RD      = 4'hc
   } cmd_t;
endpackage

// ==== src/event_latch.sv ====
// sticky event register with masked summary bit
`timescale 1ns/100ps
module event_latch #(
   parameter int           W    = 8,
   parameter logic [W-1:0] USED = '1,
   parameter logic [W-1:0] RST  = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // events and clearing
   input  wire logic [W-1:0] set_bits,
   input  wire logic         clear,
   input  wire logic [W-1:0] mask,
   // state
   output logic      [W-1:0] events,
   output logic              summary
);
   typedef struct packed {
      logic [W-1:0] ev;
      logic         sum;
   } latch_t;

   latch_t s_reg;
   latch_t s_next;

   always_comb begin
      s_next = s_reg;
      // set wins over a same-cycle clear, unused bits forced low
      s_next.ev  = ((clear ? '0 : s_reg.ev) | set_bits) & USED;
      s_next.sum = |(s_next.ev & mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{ev: RST, sum: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign events  = s_reg.ev;
   assign summary = s_reg.sum;
endmodule

// ==== src/error_queue.sv ====
// first-in first-out store of error codes
`timescale 1ns/100ps
module error_queue (
   // clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   // write side
   input  wire logic                              push,
   input  wire logic [status_pkg::CODE_W-1:0]     push_code,
   // read side
   input  wire logic                              pop,
   output logic      [status_pkg::CODE_W-1:0]     head,
   output logic      [status_pkg::ERRQ_CNT_W-1:0] count
);
   localparam logic [status_pkg::ERRQ_CNT_W-1:0] LAST = 5'(status_pkg::ERRQ_DEPTH - 1);
   localparam logic [status_pkg::ERRQ_CNT_W-1:0] FULL = 5'(status_pkg::ERRQ_DEPTH);

   typedef struct packed {
      logic [status_pkg::ERRQ_DEPTH-1:0][status_pkg::CODE_W-1:0] mem;
      logic [status_pkg::ERRQ_CNT_W-1:0]                         rd;
      logic [status_pkg::ERRQ_CNT_W-1:0]                         wr;
      logic [status_pkg::ERRQ_CNT_W-1:0]                         cnt;
   } queue_t;

   queue_t s_reg;
   queue_t s_next;
   logic   do_push;
   logic   do_pop;

   assign do_push = push && (s_reg.cnt != FULL);
   assign do_pop  = pop && (s_reg.cnt != '0);

   always_comb begin
      s_next = s_reg;
      if (do_push) begin
         s_next.mem[s_reg.wr] = push_code;
         s_next.wr = (s_reg.wr == LAST) ? '0 : s_reg.wr + 5'h01;
      end
      // oldest entry leaves first
      if (do_pop) begin
         s_next.rd = (s_reg.rd == LAST) ? '0 : s_reg.rd + 5'h01;
      end
      if (do_push && !do_pop) begin
         s_next.cnt = s_reg.cnt + 5'h01;
      end else if (do_pop && !do_push) begin
         s_next.cnt = s_reg.cnt - 5'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign head  = s_reg.mem[s_reg.rd];
   assign count = s_reg.cnt;
endmodule

// ==== testbench/bus_controller_model.sv ====
// remote controller model issuing status commands
`timescale 1ns/100ps
module bus_controller_model (
   // command port
   input  wire logic   clk,
   output logic        cmd_valid = 1'b0,
   output logic [3:0]  cmd_op = 4'h0,
   output logic [15:0] cmd_arg = 16'h0
);
   // one command a cycle; an idle port carries no stale command
   task automatic issue(input logic v, input logic [3:0] o, input logic [15:0] a);
      @(negedge clk);
      cmd_valid = v;
      cmd_op = v ? o : ~cmd_op;
      cmd_arg = v ? a : ~cmd_arg;
   endtask
endmodule

// ==== testbench/tb_status_event_reporting.sv ====
// self-checking bench of the status event reporting block
`timescale 1ns/100ps
module tb_status_event_reporting;
   logic        clk = 1'b0, rst_n, ofull, poc, cv, rv, pocs, halt, pend;
   logic [3:0]  op;
   logic [7:0]  smask, summ, mask;
   logic [11:0] ev;
   logic [15:0] ecode, arg, rdata, code, exp_q[$], codes[$];
   int          n_mismatch = 0, check_count = 0, i;
   integer      seed;
   initial forever #2 clk = ~clk;
   status_event_reporting u_status_event_reporting (.CLK(clk), .RESET_N(rst_n), .CMD_VALID(cv), .CMD_OP(op),
      .CMD_ARG(arg), .EVT_QUERY_EMPTY(ev[0]), .EVT_QUERY_INTERRUPTED(ev[1]), .EVT_BUFFERS_FULL(ev[2]),
      .EVT_SELFTEST_FAIL(ev[3]), .EVT_CAL_FAIL(ev[4]), .EVT_EXEC_ERROR(ev[5]), .EVT_SYNTAX_ERROR(ev[6]),
      .ERR_CODE(ecode), .EVT_OVLD_VOLT(ev[7]), .EVT_OVLD_CURR(ev[8]), .EVT_OVLD_OHMS(ev[9]), .EVT_LIMIT_LO(ev[10]),
      .EVT_LIMIT_HI(ev[11]), .OUT_BUF_FULL(ofull), .POC_STORED(poc), .STD_MASK_STORED(smask), .RESP_VALID(rv),
      .RESP_DATA(rdata), .STATUS_SUMMARY(summ), .POC_SETTING(pocs), .STD_MASK(mask), .READINGS_HALT(halt), .ERROR_PENDING(pend));
   bus_controller_model u_bus_controller_model (.clk(clk), .cmd_valid(cv), .cmd_op(op), .cmd_arg(arg));
   task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic cmd(input logic [3:0] o, input logic [15:0] a, input logic [15:0] e);
      if (o inside {4'h4, 4'h5, 4'h7, 4'h8, 4'hb, 4'hc})
         exp_q.push_back(e);
      u_bus_controller_model.issue(1'b1, o, a);
   endtask
   task automatic idle();
      u_bus_controller_model.issue(1'b0, 4'h0, 16'h0);
   endtask
   task automatic evt(input logic [11:0] v, input logic [15:0] c);
      @(negedge clk);
      {ev, ecode} = {v, c};
      @(negedge clk);
      ev = 12'h0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(negedge clk)
      if (rv === 1'b1)
         check("response", rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~rdata);
   initial begin
      seed = 32'h83f9e34d;
      {rst_n, ofull, poc, ev, ecode} = '0;
      smask = 8'($random(seed));
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      cmd(4'h5, 16'h0, 16'h0080);
      cmd(4'h5, 16'h0, 16'h0);
      cmd(4'h4, 16'h0, {8'h0, smask});
      $display("test power-on done");
      cmd(4'h3, 16'h0020, 16'h0);
      cmd(4'h6, 16'h0200, 16'h0);
      cmd(4'h7, 16'h0, 16'h0200);
      idle();
      code = 16'($random(seed));
      evt(12'h07f, code);
      cmd(4'h2, 16'h0, 16'h0);
      idle();
      ofull = 1'b1;
      evt(12'hf80, 16'h0);
      @(negedge clk);
      check("summary", {8'h0, summ}, 16'h0028);
      check("halt", {15'h0, halt}, 16'h1);
      ofull = 1'b0;
      cmd(4'h5, 16'h0, 16'h003d);
      check("halt", {15'h0, halt}, 16'h0);
      cmd(4'h8, 16'h0, 16'h1a03);
      cmd(4'hc, 16'h0, code);
      cmd(4'hc, 16'h0, 16'h0);
      idle();
      $display("test events done");
      code = 16'($random(seed));
      evt(12'h840, code);
      cmd(4'h1, 16'h0, 16'h0);
      cmd(4'h5, 16'h0, 16'h0);
      cmd(4'h8, 16'h0, 16'h0);
      cmd(4'h4, 16'h0, 16'h0020);
      cmd(4'hc, 16'h0, code);
      cmd(4'h9, 16'h0, 16'h0);
      cmd(4'h7, 16'h0, 16'h0);
      idle();
      $display("test clearing done");
      for (i = 0; i < 22; i++) begin
         code = 16'($random(seed));
         codes.push_back(code);
         evt(12'h001 << (i % 7), code);
      end
      check("pending", {15'h0, pend}, 16'h1);
      for (i = 0; i < 21; i++)
         cmd(4'hc, 16'h0, i < 20 ? codes[i] : 16'h0);
      idle();
      repeat (3) @(negedge clk);
      check("pending", {15'h0, pend}, 16'h0);
      $display("test error queue done");
      cmd(4'h3, 16'h00ff, 16'h0);
      cmd(4'h6, 16'h1a03, 16'h0);
      cmd(4'ha, 16'h0001, 16'h0);
      cmd(4'hb, 16'h0, 16'h0001);
      idle();
      poc = 1'b1;
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      check("std mask", {8'h0, mask}, 16'h0);
      check("poc setting", {15'h0, pocs}, 16'h1);
      cmd(4'h5, 16'h0, 16'h0080);
      cmd(4'h7, 16'h0, 16'h0);
      cmd(4'ha, 16'h0, 16'h0);
      cmd(4'hb, 16'h0, 16'h0);
      idle();
      repeat (3) @(negedge clk);
      $display("test second power-on done");
      check("drained", 16'(exp_q.size()), 16'h0);
      conclude();
   end
endmodule
